// File: common/session_pkg.sv
/*
 * Constants, register map, message encodings and states of the
 * resource session generator.
 * Assumes an APB master on a 200 MHz clock and a message transport that
 * takes one decoded message per valid/ready handshake.
 */
// Notes on behaviour
// RL1 - only upstream asks for resource information
// RL2 - resource request answered by opening a session
// RL3 - only we send open; it starts session
// RL4 - open carries message count 0 to 999
// RL5 - exactly announced messages, then close
// RL6 - close only after all announced messages
// RL7 - upstream error message aborts the session
// RL8 - error carries four-character cause, mismatch code
// RL9 - capacity messages only inside open session
// RL10 - at most one main, one fast per session
// RL11 - capacity is current allocation, sent by us
// RL12 - main variant: tag plus units 0..864
// RL13 - fast variant: bytes per second 0..5334
// RL14 - stream limits in session, one per type
// RL15 - stream limits give count and bitrate
// RL16 - allocation always sent inside a session
// RL17 - upstream counts messages, flags count mismatch
// RL18 - upstream discards capacity messages outside session
package session_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_MSC_CAP   = 8'h04;
	localparam logic [7:0] OFF_FIC_BPS   = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
	localparam logic [7:0] OFF_ERR_CAUSE = 8'h18;
	localparam logic [7:0] OFF_SENT      = 8'h1C;
	localparam logic [1:0] OFF_TABLE_HI  = 2'h1;

	// ==========================================================
	// field positions and reset values
	localparam int CTRL_START  = 0;
	localparam int CTRL_MSC_EN = 1;
	localparam int CTRL_FIC_EN = 2;
	localparam int CTRL_ST_LSB = 4;
	localparam int N_STREAM    = 4;
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_ABORT   = 1;
	localparam int IRQ_REQ     = 2;
	localparam int IRQ_W       = 3;
	localparam int FW          = 18;
	localparam int N_WORD      = 3;
	localparam logic [FW-1:0] CAP_RESET = 18'h00000;

	// ==========================================================
	// value limits
	localparam logic [9:0]    MAX_MSG_COUNT = 10'h3E7;
	localparam logic [FW-1:0] MAX_CAP_UNITS = 18'h00360;
	localparam logic [FW-1:0] MAX_FIC_BPS   = 18'h014D6;

	// ==========================================================
	// message encodings
	typedef enum logic [1:0] {
		KIND_OPEN    = 2'b00,
		KIND_CLOSE   = 2'b01,
		KIND_CHANCAP = 2'b10,
		KIND_STREAM_LIMIT_MESSAGE = 2'b11
	} msg_kind_t;

	localparam logic [1:0] SEL_MAIN = 2'b00;
	localparam logic [1:0] SEL_FAST = 2'b01;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_OPEN  = 3'b001,
		ST_MAIN  = 3'b010,
		ST_FAST  = 3'b011,
		ST_FETCH = 3'b100,
		ST_LIMIT = 3'b101,
		ST_CLOSE = 3'b110
	} sess_state_t;

endpackage : session_pkg

// File: rtl/limit_table.sv
/*
 * Stream limit table: one entry per stream type, written word by word,
 * read as a whole entry with registered read data.
 * Assumes a single clock; read data appear one cycle after rd_en.
 */
`timescale 1ns/1ps
module limit_table
	import session_pkg::*;
#(
	parameter int LANE_W = FW,
	parameter int LANES  = N_WORD,
	parameter int DEPTH  = N_STREAM
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       wr_en,
	input  wire logic [$clog2(DEPTH)-1:0]   wr_idx,
	input  wire logic [1:0]                 wr_lane,
	input  wire logic [LANE_W-1:0]          wr_data,
	input  wire logic                       rd_en,
	input  wire logic [$clog2(DEPTH)-1:0]   rd_idx,
	output logic      [LANES*LANE_W-1:0]    rd_data
);

	logic [LANES*LANE_W-1:0] mem_r [DEPTH];

	// ==========================================================
	// storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (wr_en && (int'(wr_lane) < LANES)) begin
			mem_r[wr_idx][wr_lane*LANE_W +: LANE_W] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem_r[rd_idx];
		end
	end

endmodule : limit_table

// File: rtl/resource_session.sv
/*
 * Downstream resource session generator with APB registers.
 * Answers a resource request (or a software start) with an open
 * message holding the count, the enabled capacity and stream limit
 * messages, and a close message. An upstream error aborts the session.
 * Assumes the transport takes each message on TX_VALID and TX_READY high.
 */
`timescale 1ns/1ps
module resource_session
	import session_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        RX_INFO_REQ,
	input  wire logic        RX_ERROR,
	input  wire logic [31:0] RX_ERR_CAUSE,
	output logic             TX_VALID,
	input  wire logic        TX_READY,
	output logic      [1:0]  TX_KIND,
	output logic      [1:0]  TX_SEL,
	output logic      [17:0] TX_FIELD_A,
	output logic      [17:0] TX_FIELD_B,
	output logic      [17:0] TX_FIELD_C,
	output logic             SESSION_OPEN,
	output logic             IRQ
);

	// ==========================================================
	// apb decode
	logic              setup_w;
	logic              wr_w;
	logic              is_table;
	logic              mapped_w;
	logic [31:0]       rd_mux;
	logic [N_STREAM-1:0] st_en_r;
	logic              msc_en_r;
	logic              fic_en_r;
	logic [FW-1:0]     msc_cap_r;
	logic [FW-1:0]     fic_bps_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [31:0]       err_cause_r;
	logic [9:0]        sent_r;
	logic [9:0]        count_r;
	sess_state_t       state_r;
	sess_state_t       state_nxt;

	assign setup_w  = PSEL && !PENABLE;
	assign wr_w     = PSEL && PENABLE && PWRITE && PREADY;
	assign is_table = (PADDR[7:6] == OFF_TABLE_HI) && (PADDR[3:2] != 2'h3);
	assign mapped_w = is_table || (PADDR[7:5] == 3'h0 && PADDR[1:0] == 2'h0);

	assign rd_mux =
		(PADDR == OFF_CTRL)      ? {24'h000000, st_en_r, 1'b0, fic_en_r, msc_en_r, 1'b0} :
		(PADDR == OFF_MSC_CAP)   ? {14'h0000, msc_cap_r} :
		(PADDR == OFF_FIC_BPS)   ? {14'h0000, fic_bps_r} :
		(PADDR == OFF_STATUS)    ? {12'h000, count_r, 5'h00, state_r, 1'b0, SESSION_OPEN} :
		(PADDR == OFF_IRQ_STAT)  ? {29'h00000000, irq_stat_r} :
		(PADDR == OFF_IRQ_MASK)  ? {29'h00000000, irq_mask_r} :
		(PADDR == OFF_ERR_CAUSE) ? err_cause_r :
		(PADDR == OFF_SENT)      ? {22'h000000, sent_r} :
		32'h00000000;

	// zero-wait access: ready rises in the access phase
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup_w;
			PRDATA  <= setup_w ? rd_mux : 32'h00000000;
			PSLVERR <= setup_w && !mapped_w;
		end
	end

	// ==========================================================
	// configuration registers
	logic start_w;
	assign start_w = wr_w && PADDR == OFF_CTRL && PWDATA[CTRL_START];

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			msc_en_r   <= 1'b0;
			fic_en_r   <= 1'b0;
			st_en_r    <= '0;
			msc_cap_r  <= CAP_RESET;
			fic_bps_r  <= CAP_RESET;
			irq_mask_r <= '0;
		end else if (wr_w) begin
			if (PADDR == OFF_CTRL) begin
				msc_en_r <= PWDATA[CTRL_MSC_EN];
				fic_en_r <= PWDATA[CTRL_FIC_EN];
				st_en_r  <= PWDATA[CTRL_ST_LSB +: N_STREAM];
			end
			if (PADDR == OFF_MSC_CAP) begin
				msc_cap_r <= PWDATA[FW-1:0];
			end
			if (PADDR == OFF_FIC_BPS) begin
				fic_bps_r <= PWDATA[FW-1:0];
			end
			if (PADDR == OFF_IRQ_MASK) begin
				irq_mask_r <= PWDATA[IRQ_W-1:0];
			end
		end
	end

	// ==========================================================
	// stream limit table
	logic [1:0]          type_r;
	logic                tbl_rd_w;
	logic [N_WORD*FW-1:0] tbl_data;

	limit_table u_table (
		.clk     (CLK),
		.rst_n   (RESETN),
		.wr_en   (wr_w && is_table),
		.wr_idx  (PADDR[5:4]),
		.wr_lane (PADDR[3:2]),
		.wr_data (PWDATA[FW-1:0]),
		.rd_en   (tbl_rd_w),
		.rd_idx  (type_r),
		.rd_data (tbl_data)
	);

	// ==========================================================
	// session sequencer
	logic                hs_w;
	logic                abort_w;
	logic                go_w;
	logic [N_STREAM-1:0] sst_r;
	logic                smsc_r;
	logic                sfic_r;
	logic [9:0]          ann_w;
	logic [FW-1:0]       msc_units_w;
	logic [FW-1:0]       fic_rate_w;

	assign hs_w    = TX_VALID && TX_READY;
	assign abort_w = RX_ERROR && SESSION_OPEN; // RL7
	assign go_w    = (RX_INFO_REQ || start_w) && state_r == ST_IDLE; // RL2
	assign ann_w   = 10'(msc_en_r) + 10'(fic_en_r) + 10'(st_en_r[0]) + 10'(st_en_r[1])
		+ 10'(st_en_r[2]) + 10'(st_en_r[3]);
	assign msc_units_w = (msc_cap_r > MAX_CAP_UNITS) ? MAX_CAP_UNITS : msc_cap_r; // RL12
	assign fic_rate_w  = (fic_bps_r > MAX_FIC_BPS) ? MAX_FIC_BPS : fic_bps_r; // RL13
	assign tbl_rd_w    = state_r == ST_FETCH;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  state_nxt = go_w ? ST_OPEN : ST_IDLE; // RL16
			ST_OPEN:  state_nxt = !hs_w ? ST_OPEN : smsc_r ? ST_MAIN :
				sfic_r ? ST_FAST : ST_FETCH;
			ST_MAIN:  state_nxt = !hs_w ? ST_MAIN : sfic_r ? ST_FAST : ST_FETCH; // RL10
			ST_FAST:  state_nxt = hs_w ? ST_FETCH : ST_FAST; // RL10
			ST_FETCH: state_nxt = sst_r[type_r] ? ST_LIMIT :
				(type_r == 2'h3) ? ST_CLOSE : ST_FETCH; // RL14
			ST_LIMIT: state_nxt = !hs_w ? ST_LIMIT :
				(type_r == 2'h3) ? ST_CLOSE : ST_FETCH;
			ST_CLOSE: state_nxt = hs_w ? ST_IDLE : ST_CLOSE; // RL6
			default:  state_nxt = ST_IDLE;
		endcase
		if (abort_w) begin
			state_nxt = ST_IDLE; // RL7
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r      <= ST_IDLE;
			SESSION_OPEN <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			SESSION_OPEN <= state_nxt != ST_IDLE && state_nxt != ST_OPEN; // RL3
		end
	end

	// snapshot of the enables so the announced count cannot drift
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			smsc_r  <= 1'b0;
			sfic_r  <= 1'b0;
			sst_r   <= '0;
			count_r <= 10'h000;
		end else if (go_w) begin
			smsc_r  <= msc_en_r;
			sfic_r  <= fic_en_r;
			sst_r   <= st_en_r;
			count_r <= ann_w; // RL4
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			type_r <= 2'h0;
			sent_r <= 10'h000;
		end else begin
			if (go_w) begin
				type_r <= 2'h0;
				sent_r <= 10'h000;
			end else if (state_r == ST_FETCH && !sst_r[type_r] && type_r != 2'h3) begin
				type_r <= type_r + 2'h1;
			end else if (state_r == ST_LIMIT && hs_w && type_r != 2'h3) begin
				type_r <= type_r + 2'h1;
			end
			if (hs_w && (state_r == ST_MAIN || state_r == ST_FAST || state_r == ST_LIMIT)) begin
				sent_r <= sent_r + 10'h001; // RL5
			end
		end
	end

	// ==========================================================
	// message output
	logic          load_w;
	logic [1:0]    kind_w;
	logic [1:0]    sel_w;
	logic [FW-1:0] fa_w;
	logic [FW-1:0] fb_w;
	logic [FW-1:0] fc_w;

	assign load_w = !TX_VALID && !abort_w && (state_r == ST_OPEN || state_r == ST_MAIN
		|| state_r == ST_FAST || state_r == ST_LIMIT || state_r == ST_CLOSE);
	assign kind_w = (state_r == ST_OPEN)  ? KIND_OPEN :
		(state_r == ST_CLOSE) ? KIND_CLOSE :
		(state_r == ST_LIMIT) ? KIND_STREAM_LIMIT_MESSAGE : KIND_CHANCAP;
	assign sel_w  = (state_r == ST_LIMIT) ? type_r :
		(state_r == ST_FAST) ? SEL_FAST : SEL_MAIN;
	assign fa_w   = (state_r == ST_OPEN) ? {8'h00, count_r} : // RL4
		(state_r == ST_MAIN) ? msc_units_w : // RL11
		(state_r == ST_FAST) ? fic_rate_w : // RL11
		(state_r == ST_LIMIT) ? tbl_data[0 +: FW] : CAP_RESET; // RL15
	assign fb_w   = (state_r == ST_LIMIT) ? tbl_data[FW +: FW] : CAP_RESET; // RL15
	assign fc_w   = (state_r == ST_LIMIT) ? tbl_data[2*FW +: FW] : CAP_RESET;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			TX_VALID <= 1'b0;
		end else if (abort_w || hs_w) begin
			TX_VALID <= 1'b0;
		end else if (load_w) begin
			TX_VALID <= 1'b1; // RL9
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			TX_KIND    <= KIND_OPEN;
			TX_SEL     <= SEL_MAIN;
			TX_FIELD_A <= CAP_RESET;
			TX_FIELD_B <= CAP_RESET;
			TX_FIELD_C <= CAP_RESET;
		end else if (load_w) begin
			TX_KIND    <= kind_w;
			TX_SEL     <= sel_w;
			TX_FIELD_A <= fa_w;
			TX_FIELD_B <= fb_w;
			TX_FIELD_C <= fc_w;
		end
	end

	// ==========================================================
	// interrupts: set wins over write-one-to-clear
	logic [IRQ_W-1:0] ev_w;
	logic [IRQ_W-1:0] clr_w;

	assign ev_w[IRQ_DONE]  = hs_w && state_r == ST_CLOSE;
	assign ev_w[IRQ_ABORT] = abort_w;
	assign ev_w[IRQ_REQ]   = RX_INFO_REQ;
	assign clr_w = (wr_w && PADDR == OFF_IRQ_STAT) ? PWDATA[IRQ_W-1:0] : '0;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_stat_r  <= '0;
			IRQ         <= 1'b0;
			err_cause_r <= 32'h00000000;
		end else begin
			irq_stat_r <= (irq_stat_r & ~clr_w) | ev_w;
			IRQ        <= |(((irq_stat_r & ~clr_w) | ev_w) & irq_mask_r);
			if (abort_w) begin
				err_cause_r <= RX_ERR_CAUSE; // RL8
			end
		end
	end

	// ==========================================================
	// checks
	a_count_range: assert property (@(posedge CLK) disable iff (!RESETN) // RL4
		TX_VALID && TX_KIND == KIND_OPEN |-> TX_FIELD_A <= 18'(MAX_MSG_COUNT))
		else $error("announced count out of range");
	a_close_count: assert property (@(posedge CLK) disable iff (!RESETN) // RL6
		TX_VALID && TX_KIND == KIND_CLOSE |-> sent_r == count_r)
		else $error("close before all announced messages");
	a_cap_inside: assert property (@(posedge CLK) disable iff (!RESETN) // RL9
		TX_VALID && TX_KIND != KIND_OPEN |-> SESSION_OPEN)
		else $error("session message outside open session");
	a_main_limit: assert property (@(posedge CLK) disable iff (!RESETN) // RL12
		TX_VALID && TX_KIND == KIND_CHANCAP && TX_SEL == SEL_MAIN
		|-> TX_FIELD_A <= MAX_CAP_UNITS)
		else $error("main capacity above limit");
	a_fast_limit: assert property (@(posedge CLK) disable iff (!RESETN) // RL13
		TX_VALID && TX_KIND == KIND_CHANCAP && TX_SEL == SEL_FAST
		|-> TX_FIELD_A <= MAX_FIC_BPS)
		else $error("fast capacity above limit");
	a_req_opens: assert property (@(posedge CLK) disable iff (!RESETN) // RL2
		RX_INFO_REQ && state_r == ST_IDLE |-> ##2 TX_VALID && TX_KIND == KIND_OPEN)
		else $error("request not answered by open");
	a_abort_stop: assert property (@(posedge CLK) disable iff (!RESETN) // RL7
		abort_w |=> !TX_VALID && !SESSION_OPEN && state_r == ST_IDLE)
		else $error("error did not abort session");
	a_msg_hold: assert property (@(posedge CLK) disable iff (!RESETN) // RL5
		TX_VALID && !TX_READY && !abort_w |=> TX_VALID && $stable(TX_KIND)
		&& $stable(TX_FIELD_A))
		else $error("message dropped before taken");
	a_sent_bound: assert property (@(posedge CLK) disable iff (!RESETN) // RL5
		SESSION_OPEN |-> sent_r <= count_r)
		else $error("more messages than announced");
	a_open_first: assert property (@(posedge CLK) disable iff (!RESETN) // RL3
		hs_w && TX_KIND == KIND_OPEN |=> SESSION_OPEN)
		else $error("open message did not open session");

	c_full: cover property (@(posedge CLK) disable iff (!RESETN)
		hs_w && TX_KIND == KIND_CLOSE && count_r == 10'h006);
	c_empty: cover property (@(posedge CLK) disable iff (!RESETN)
		hs_w && TX_KIND == KIND_CLOSE && count_r == 10'h000);
	c_abort: cover property (@(posedge CLK) disable iff (!RESETN)
		abort_w && state_r == ST_LIMIT);
	c_irq: cover property (@(posedge CLK) disable iff (!RESETN) $rose(IRQ));

endmodule : resource_session

// File: tb/upstream_peer.sv
/*
 * Upstream peer model: takes messages and counts them per session.
 * Assumes one message per valid/ready handshake from the block.
 */
`timescale 1ns/1ps
module upstream_peer
	import session_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        tx_valid,
	input  wire logic [1:0]  tx_kind,
	input  wire logic [17:0] tx_field_a,
	input  wire logic        session_open,
	input  wire logic        stall,
	input  wire logic        slow,
	output logic             tx_ready,
	output logic             bad
);
	logic [1:0]  ph_r;
	logic [17:0] want_r;
	logic [17:0] got_r;
	logic        in_r;
	logic        was_r;
	wire         take = tx_valid && tx_ready;
	// prompt, or one cycle in four
	assign tx_ready = !stall && (!slow || ph_r == 2'b00);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 2'b00;
			want_r <= 18'h00000;
			got_r <= 18'h00000;
			in_r <= 1'b0;
			was_r <= 1'b0;
			bad <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'b01;
			was_r <= session_open;
			if (take && tx_kind == KIND_OPEN) begin
				in_r <= 1'b1;
				want_r <= tx_field_a;
				got_r <= 18'h00000;
			end else if (take && tx_kind == KIND_CLOSE) begin
				in_r <= 1'b0;
				bad <= bad | !in_r | (got_r != want_r);
			end else if (take) begin
				bad <= bad | !in_r;
				got_r <= got_r + 18'h00001;
			end else if (was_r && !session_open) begin
				in_r <= 1'b0;
			end
		end
	end
endmodule : upstream_peer

// File: tb/tb.sv
/*
 * Bench: APB master, link stimulus, queued expectations and a watcher.
 * Assumes session_pkg and the upstream peer model.
 */
`timescale 1ns/1ps
module tb
	import session_pkg::*;
;
	localparam logic [31:0] count_mismatch_code = 32'h4E4D5347;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic        info_req = 1'b0;
	logic        rx_error = 1'b0;
	logic [31:0] err_cause = 32'h00000000;
	logic        stall = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, tx_valid, tx_ready, session_open, irq, peer_bad;
	logic [1:0]  tx_kind, tx_sel;
	logic [17:0] tx_a, tx_b, tx_c, mcap, fbps;
	logic [17:0] lim [4];
	logic [17:0] lim_b [4];
	logic [17:0] lim_c [4];
	logic [31:0] seed = 32'hA651AE1D;
	logic [21:0] e;
	logic [21:0] msg_q [$];
	logic [32:0] rd_q [$];
	int          bad_count = 0;
	int          checks = 0;

	always #2.5 clk = ~clk;

	resource_session resource_session_inst (
		.CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX_INFO_REQ(info_req), .RX_ERROR(rx_error),
		.RX_ERR_CAUSE(err_cause), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.TX_KIND(tx_kind), .TX_SEL(tx_sel), .TX_FIELD_A(tx_a), .TX_FIELD_B(tx_b),
		.TX_FIELD_C(tx_c), .SESSION_OPEN(session_open), .IRQ(irq)
	);
	upstream_peer upstream_peer_inst (
		.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_kind(tx_kind),
		.tx_field_a(tx_a), .session_open(session_open), .stall(stall), .slow(slow),
		.tx_ready(tx_ready), .bad(peer_bad)
	);

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task check(input logic [32:0] seen, input logic [32:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	task end_of_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] want);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) rd_q.push_back(want);
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task pulse(input logic err, input logic [31:0] cause);
		@(posedge clk);
		rx_error <= err;
		info_req <= !err;
		err_cause <= cause;
		@(posedge clk);
		rx_error <= 1'b0;
		info_req <= 1'b0;
		err_cause <= ~cause;
	endtask : pulse

	task session(input logic [7:0] en, input logic start, input logic again);
		int t;
		msg_q.push_back({KIND_OPEN, SEL_MAIN, 18'($countones(en[7:1]))});
		if (en[1])
			msg_q.push_back({KIND_CHANCAP, SEL_MAIN, (mcap > MAX_CAP_UNITS) ? MAX_CAP_UNITS : mcap});
		if (en[2])
			msg_q.push_back({KIND_CHANCAP, SEL_FAST, (fbps > MAX_FIC_BPS) ? MAX_FIC_BPS : fbps});
		for (t = 0; t < 4; t++)
			if (en[4 + t]) msg_q.push_back({KIND_STREAM_LIMIT_MESSAGE, 2'(t), lim[t]});
		msg_q.push_back({KIND_CLOSE, SEL_MAIN, 18'h00000});
		apb(1'b1, OFF_CTRL, {24'h0, en}, 33'h0);
		if (start)
			apb(1'b1, OFF_CTRL, {24'h0, en | 8'h01}, 33'h0);
		else
			pulse(1'b0, 32'h0);
		if (again) begin
			for (t = 0; t < 50 && session_open !== 1'b1; t++) @(posedge clk);
			pulse(1'b0, 32'h0);
		end
		for (t = 0; t < 500 && msg_q.size() != 0; t++) @(posedge clk);
		repeat (2) @(posedge clk);
		check(33'(msg_q.size()), 33'h0);
		check(33'(session_open), 33'h0);
	endtask : session

	// ==========================================================
	// watcher: oldest note against each result
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check({pslverr, prdata}, rd_q.pop_front());
		if (tx_valid === 1'b1 && tx_ready === 1'b1 && msg_q.size() == 0)
			check(33'(tx_valid), 33'h0);
		else if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			e = msg_q.pop_front();
			check(33'(tx_kind), 33'(e[21:20]));
			if (e[21]) check(33'(tx_sel), 33'(e[19:18]));
			if (e[21:20] != 2'b01) check(33'(tx_a), 33'(e[17:0]));
			check(33'(tx_b), (e[21:20] == 2'b11) ? 33'(lim_b[e[19:18]]) : 33'h0);
			check(33'(tx_c), (e[21:20] == 2'b11) ? 33'(lim_c[e[19:18]]) : 33'h0);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test;
	end

	// ==========================================================
	// tests
	initial begin
		int i;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) apb(1'b0, 8'(4 * i), 32'h0, 33'h0);
		apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 8'h5C, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 8'h50, 32'h0, 33'h0);
		$display("test registers done");
		mcap = 18'h00384;
		fbps = 18'h01770;
		for (i = 0; i < 4; i++) begin
			lim[i] = 18'(1000 * i + 7);
			apb(1'b1, 8'(64 + 16 * i), 32'(lim[i]), 33'h0);
			lim_b[i] = 18'(500 * i + 3);
			lim_c[i] = 18'(228000 - 11 * i);
			apb(1'b1, 8'(68 + 16 * i), 32'(lim_b[i]), 33'h0);
			apb(1'b1, 8'(72 + 16 * i), 32'(lim_c[i]), 33'h0);
		end
		apb(1'b0, 8'h44, 32'h0, 33'h0);
		apb(1'b1, OFF_MSC_CAP, 32'(mcap), 33'h0);
		apb(1'b1, OFF_FIC_BPS, 32'(fbps), 33'h0);
		apb(1'b1, OFF_IRQ_MASK, 32'h7, 33'h0);
		slow <= 1'b1;
		session(8'h26, 1'b0, 1'b1);
		check(33'(irq), 33'h1);
		apb(1'b0, OFF_IRQ_STAT, 32'h0, 33'h5);
		apb(1'b1, OFF_IRQ_MASK, 32'h0, 33'h0);
		repeat (2) @(posedge clk);
		check(33'(irq), 33'h0);
		apb(1'b1, OFF_IRQ_MASK, 32'h7, 33'h0);
		apb(1'b1, OFF_IRQ_STAT, 32'h7, 33'h0);
		repeat (2) @(posedge clk);
		check(33'(irq), 33'h0);
		$display("test full session done");
		slow <= 1'b0;
		session(8'h00, 1'b1, 1'b0);
		apb(1'b1, OFF_IRQ_STAT, 32'h7, 33'h0);
		$display("test empty session done");
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			mcap = {8'h00, seed[9:0]};
			fbps = {5'h00, seed[28:16]};
			slow <= seed[31];
			apb(1'b1, OFF_MSC_CAP, 32'(mcap), 33'h0);
			apb(1'b1, OFF_FIC_BPS, 32'(fbps), 33'h0);
			session({seed[7:4], 1'b0, seed[2:1], 1'b0}, seed[3], 1'b0);
			apb(1'b1, OFF_IRQ_STAT, 32'h7, 33'h0);
		end
		$display("test random sessions done");
		// error while opening is ignored, once open it aborts
		stall <= 1'b1;
		msg_q.push_back({KIND_OPEN, SEL_MAIN, 18'h00001});
		apb(1'b1, OFF_CTRL, 32'h2, 33'h0);
		pulse(1'b0, 32'h0);
		for (i = 0; i < 50 && tx_valid !== 1'b1; i++) @(posedge clk);
		pulse(1'b1, 32'h12345678);
		apb(1'b0, OFF_ERR_CAUSE, 32'h0, 33'h0);
		stall <= 1'b0;
		for (i = 0; i < 50 && session_open !== 1'b1; i++) @(posedge clk);
		stall <= 1'b1;
		pulse(1'b1, count_mismatch_code);
		@(posedge clk);
		check({31'h0, tx_valid, session_open}, 33'h0);
		stall <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, OFF_ERR_CAUSE, 32'h0, {1'b0, count_mismatch_code});
		apb(1'b0, OFF_IRQ_STAT, 32'h0, 33'h6);
		check(33'(peer_bad), 33'h0);
		$display("test abort done");
		end_of_test;
	end
endmodule : tb
